/* uml_defines.svh */
// Register offsets, field positions, reset values and masks for the block
`ifndef UML_DEFINES_SVH
`define UML_DEFINES_SVH

// Byte offsets of the two registers
`define UML_CTL_OFF 8'h04
`define UML_STA_OFF 8'h18

// Control register reset value and writable bits
`define UML_CTL_RST 8'h00
`define UML_CTL_WMASK 8'h1f

// Control register field positions
`define UML_BIT_DTR 0
`define UML_BIT_RTS 1
`define UML_BIT_AUX 2
`define UML_BIT_GATE 3
`define UML_BIT_LOOP 4

// Status register reset value
`define UML_STA_RST 8'h00

// Bus transfer type bit that marks an active transfer
`define UML_HTRANS_ACTIVE 1

`endif

/* uml_pkg.sv */
// Types shared by the modem control and loopback block
`default_nettype none
package uml_pkg;

  // Writable control fields, bit 0 at the bottom
  typedef struct packed {
    logic loop;          // Diagnostic loopback
    logic irq_gate_bit;  // Interrupt gate control
    logic aux_flag_a;    // Auxiliary test output
    logic rts;           // Request to send
    logic dtr;           // Data terminal ready
  } uml_ctrl_t;

  // Modem status levels, active high, bit 7 down to bit 4
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } uml_stat_t;

  // Change indicators, bit 3 down to bit 0
  typedef struct packed {
    logic ddcd;
    logic teri;
    logic ddsr;
    logic dcts;
  } uml_delta_t;

  // Register access request from the bus port
  typedef struct packed {
    logic rd;             // Read taken in its address phase
    logic [7:0] rd_addr;  // Read byte address
    logic wr;             // Write in its data phase
    logic [7:0] wr_addr;  // Write byte address
    logic [31:0] wdata;   // Write data
  } uml_req_t;

endpackage : uml_pkg
`default_nettype wire

/* uml_ahb_port.sv */
// AHB-Lite slave front end: turns bus phases into register requests
`default_nettype none
module uml_ahb_port
  import uml_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output uml_req_t req
);
`include "uml_defines.svh"

  logic take;            // Address phase accepted this edge
  logic dp_write;        // A write data phase is in progress
  logic [7:0] dp_addr;   // Address held for the data phase

  // Accept any active transfer once the previous one is done
  assign take = hsel & htrans[`UML_HTRANS_ACTIVE] & hready;

  // Address phase capture for the following write data phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_write <= take & hwrite;
      dp_addr <= haddr;
    end
  end

  // Never stalls and never errors: zero wait states, always OKAY
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Reads act in the address phase so hrdata is ready in the data phase
  always_comb begin
    req.rd = take & ~hwrite;
    req.rd_addr = haddr;
    req.wr = dp_write & hready;
    req.wr_addr = dp_addr;
    req.wdata = hwdata;
  end

endmodule : uml_ahb_port
`default_nettype wire

/* uml_modem_loop.sv */
// Modem control register, modem status and local diagnostic loopback
`default_nettype none
module uml_modem_loop
  import uml_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial path to and from the UART shifters
  input wire logic tx_shift_out,
  output logic rx_shift_in,
  // Device pins
  output logic txd_pin,
  input wire logic rxd_pin,
  output logic dtr_pin_n,
  output logic rts_pin_n,
  output logic irq_gate_pin_n,
  input wire logic cts_pin_n,
  input wire logic dsr_pin_n,
  input wire logic dcd_pin_n,
  input wire logic ri_pin_n,
  // Modem status towards the UART interrupt logic
  output logic [7:0] modem_line_status,
  output logic modem_change
);
`include "uml_defines.svh"

  uml_req_t req;            // Register requests from the bus port
  uml_ctrl_t ctrl;          // Control register fields
  uml_ctrl_t next_ctrl;     // Control value after this edge
  uml_stat_t stat_now;      // Sampled status levels
  uml_stat_t stat_prev;     // Status levels one cycle earlier
  uml_stat_t next_stat;     // Status source chosen by the mode
  uml_delta_t delta;        // Sticky change indicators
  uml_delta_t next_delta;   // Change indicators after this edge
  uml_delta_t hit;          // Changes seen this cycle
  logic msr_read;           // Status register read taken now

  // The width check is the master's job; only words are issued
  logic unused_size;
  assign unused_size = ^hsize;

  // Bus port: zero-wait AHB-Lite handshake
  uml_ahb_port uml_ahb_port_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req)
  );

  // Control byte as software sees it, reserved bits zero
  function automatic logic [7:0] ctrl_byte(input uml_ctrl_t c);
    ctrl_byte = {3'b000, c};
  endfunction : ctrl_byte

  // Status byte: levels in the upper nibble, changes in the lower
  function automatic logic [7:0] stat_byte(input uml_stat_t s,
                                           input uml_delta_t d);
    stat_byte = {s, d};
  endfunction : stat_byte

  // Next control value; only the five defined bits take the write
  always_comb begin
    next_ctrl = ctrl;
    if (req.wr && req.wr_addr == `UML_CTL_OFF) begin
      // Reserved bits are never stored, so no stale value can read back
      next_ctrl = uml_ctrl_t'(req.wdata[4:0] & 5'(`UML_CTL_WMASK));
    end
  end

  // Control register, cleared by reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= uml_ctrl_t'(5'(`UML_CTL_RST));
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Pin drive follows the new control value at the same edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dtr_pin_n <= 1'b1;
      rts_pin_n <= 1'b1;
      irq_gate_pin_n <= 1'b1;
    end else if (next_ctrl.loop) begin
      // Loopback parks every modem output inactive
      dtr_pin_n <= 1'b1;
      rts_pin_n <= 1'b1;
      irq_gate_pin_n <= 1'b1;
    end else begin
      // Normal mode: each pin is the inverse of its bit
      dtr_pin_n <= ~next_ctrl.dtr;
      rts_pin_n <= ~next_ctrl.rts;
      irq_gate_pin_n <= ~next_ctrl.irq_gate_bit;
    end
  end

  // Serial path; a level path carries data and break alike
  // One flop of latency keeps the pins free of decode glitches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txd_pin <= 1'b1;
      rx_shift_in <= 1'b1;
    end else if (next_ctrl.loop) begin
      txd_pin <= 1'b1;
      rx_shift_in <= tx_shift_out;
    end else begin
      txd_pin <= tx_shift_out;
      rx_shift_in <= rxd_pin;
    end
  end

  // Status source: pins in normal mode, control bits in loopback
  always_comb begin
    if (next_ctrl.loop) begin
      next_stat.dsr = next_ctrl.dtr;
      next_stat.cts = next_ctrl.rts;
      next_stat.ri = next_ctrl.aux_flag_a;
      next_stat.dcd = next_ctrl.irq_gate_bit;
    end else begin
      next_stat.dsr = ~dsr_pin_n;
      next_stat.cts = ~cts_pin_n;
      next_stat.ri = ~ri_pin_n;
      next_stat.dcd = ~dcd_pin_n;
    end
  end

  // Status levels and their one-cycle history
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_now <= uml_stat_t'(4'h0);
      stat_prev <= uml_stat_t'(4'h0);
    end else begin
      stat_now <= next_stat;
      stat_prev <= stat_now;
    end
  end

  // Change detection; ring indicator counts only its trailing edge,
  // so a ring burst is flagged once it has ended
  always_comb begin
    hit.dcts = stat_now.cts ^ stat_prev.cts;
    hit.ddsr = stat_now.dsr ^ stat_prev.dsr;
    hit.teri = stat_prev.ri & ~stat_now.ri;
    hit.ddcd = stat_now.dcd ^ stat_prev.dcd;
  end

  // Read of the status register clears the changes it returns
  // The clear lands at the address phase edge, with the read data
  assign msr_read = req.rd && req.rd_addr == `UML_STA_OFF;

  // New changes win over the clearing read in the same cycle
  always_comb begin
    next_delta = msr_read ? uml_delta_t'(4'h0) : delta;
    next_delta = next_delta | hit;
  end

  // Sticky change indicators
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delta <= uml_delta_t'(4'h0);
    end else begin
      delta <= next_delta;
    end
  end

  // Status outputs towards the UART interrupt logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      modem_line_status <= `UML_STA_RST;
      modem_change <= 1'b0;
    end else begin
      modem_line_status <= stat_byte(stat_now, next_delta);
      modem_change <= |next_delta;
    end
  end

  // Read data, loaded at the address phase; a write still in its data
  // phase is forwarded so a back-to-back read sees it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.rd_addr)
        `UML_CTL_OFF: hrdata <= {24'h00_0000, ctrl_byte(next_ctrl)};
        `UML_STA_OFF: hrdata <= {24'h00_0000, stat_byte(stat_now, delta)};
        default: hrdata <= 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
  end

  // Checks and coverage
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Loop status pushed one edge through the pin flops
  logic loop_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_q <= 1'b0;
    end else begin
      loop_q <= ctrl.loop;
    end
  end

  tx_idle_a: assert property (ctrl.loop |-> txd_pin)
    else $error("serial output not high in loopback");

  gate_high_a: assert property (ctrl.loop |-> irq_gate_pin_n)
    else $error("interrupt gate pin not high in loopback");

  modem_idle_a: assert property (ctrl.loop |-> dtr_pin_n && rts_pin_n)
    else $error("modem outputs not inactive in loopback");

  rx_loop_a: assert property (
    ctrl.loop && loop_q |-> rx_shift_in == $past(tx_shift_out))
    else $error("receiver input not fed from transmitter");

  rx_pin_a: assert property (
    !ctrl.loop && !loop_q |-> rx_shift_in == $past(rxd_pin)
      && txd_pin == $past(tx_shift_out))
    else $error("serial pins not connected in normal mode");

  pin_norm_a: assert property (
    !ctrl.loop |-> dtr_pin_n == !ctrl.dtr && rts_pin_n == !ctrl.rts
      && irq_gate_pin_n == !ctrl.irq_gate_bit)
    else $error("modem pin polarity wrong in normal mode");

  // Status takes the new control value at the same edge, so no lag here
  stat_loop_a: assert property (
    ctrl.loop && loop_q |-> stat_now == {ctrl.irq_gate_bit,
      ctrl.aux_flag_a, ctrl.dtr, ctrl.rts})
    else $error("status inputs not driven by control bits");

  // Pins may move freely in loopback; with control steady, status may not
  stat_pin_a: assert property (
    (ctrl.loop && $changed(cts_pin_n)) ##1 (ctrl.loop && $stable(ctrl))
      |-> $stable(stat_now))
    else $error("status follows pins during loopback");

  // The flag and its summary output both rise one edge after the change
  delta_set_a: assert property (
    stat_now.cts != stat_prev.cts |=> delta.dcts && modem_change)
    else $error("status change not flagged");

  reserved_a: assert property (
    $past(req.rd) && $past(req.rd_addr) == `UML_CTL_OFF
      |-> hrdata[31:5] == 27'h0)
    else $error("reserved control bits read nonzero");

  reset_ctrl_a: assert property (
    $rose(rst_b) |-> ctrl_byte(ctrl) == `UML_CTL_RST)
    else $error("control register not zero after reset");

  stat_norm_a: assert property (
    !ctrl.loop |-> stat_now == ~{$past(dcd_pin_n), $past(ri_pin_n),
      $past(dsr_pin_n), $past(cts_pin_n)})
    else $error("status levels not taken from the pins");

  cover_loop_c: cover property ($rose(ctrl.loop));
  cover_exit_c: cover property ($fell(ctrl.loop) ##[1:4] msr_read);
  cover_race_c: cover property (msr_read && |hit);
  cover_break_c: cover property (ctrl.loop && !tx_shift_out [*8]);
  cover_pin_c: cover property (ctrl.loop && $changed(cts_pin_n));

endmodule : uml_modem_loop
`default_nettype wire

/* uml_modem_model.sv */
// Modem model: drives the receive and status pins at commanded levels
`default_nettype none
module uml_modem_model (
  input wire logic sys_clk,
  input wire logic rxd_lvl, // Line level on the receive pin
  input wire logic [3:0] act, // Asserted cts, dsr, dcd, ri
  output logic rxd_pin,
  output logic cts_pin_n,
  output logic dsr_pin_n,
  output logic dcd_pin_n,
  output logic ri_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins take the commanded levels by non-blocking update at each edge,
  // so the design samples them one edge later with no race
  always @(posedge sys_clk) begin
    rxd_pin <= rxd_lvl;
    {cts_pin_n, dsr_pin_n, dcd_pin_n, ri_pin_n} <= ~act;
  end
endmodule : uml_modem_model
`default_nettype wire

/* uml_modem_loop_test.sv */
// Testbench for the modem control register and diagnostic loopback
`default_nettype none
module uml_modem_loop_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = 8'h04; // Control register
  localparam logic [7:0] STA = 8'h18; // Status register
  logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, tx_shift_out;
  logic rx_shift_in, txd_pin, rxd_pin, dtr_pin_n, rts_pin_n;
  logic irq_gate_pin_n, cts_pin_n, dsr_pin_n, dcd_pin_n, ri_pin_n;
  logic modem_change, rxd_lvl;
  logic [1:0] htrans;
  logic [3:0] act;
  logic [7:0] haddr, modem_line_status;
  logic [31:0] hwdata, hrdata, q;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  uml_modem_loop uml_modem_loop_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
    .txd_pin(txd_pin), .rxd_pin(rxd_pin), .dtr_pin_n(dtr_pin_n),
    .rts_pin_n(rts_pin_n), .irq_gate_pin_n(irq_gate_pin_n),
    .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n),
    .dcd_pin_n(dcd_pin_n), .ri_pin_n(ri_pin_n),
    .modem_line_status(modem_line_status), .modem_change(modem_change));
  uml_modem_model uml_modem_model_i (.sys_clk(sys_clk), .rxd_lvl(rxd_lvl),
    .act(act), .rxd_pin(rxd_pin), .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n), .dcd_pin_n(dcd_pin_n), .ri_pin_n(ri_pin_n));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic test_done();
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Compare one value, reporting a mismatch at once
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One single word transfer; waits on hready in each phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  // Read a register and compare with the expected word
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk("rdata", {24'h0, e}, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  // Let a few edges pass, then compare {txd, gate, rts, dtr, rx_in}
  task automatic pins(input logic [4:0] e);
    repeat (3) @(posedge sys_clk);
    chk("pins", {27'h0, e}, {27'h0, txd_pin, irq_gate_pin_n,
      rts_pin_n, dtr_pin_n, rx_shift_in});
  endtask : pins
  // Hang guard: a whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {tx_shift_out, rxd_lvl, act} = 6'h30;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(CTL, 8'h00);
    pins(5'h1f);
    // Normal mode: pins follow the bits inverted, data passes through
    bus(1'b1, CTL, 32'h0b);
    pins(5'h11);
    tx_shift_out <= 1'b0;
    rxd_lvl <= 1'b0;
    pins(5'h00);
    bus(1'b1, CTL, 32'h00);
    act <= 4'hf;
    pins(5'h0e);
    rd(STA, 8'hfb);
    rd(STA, 8'hf0);
    chk("status", 32'hf0, {24'h0, modem_line_status});
    // Loopback: pins parked, status from control bits; reserved ignored
    rxd_lvl <= 1'b1;
    bus(1'b1, CTL, 32'hf0);
    rd(CTL, 8'h10);
    pins(5'h1e);
    chk("change", 32'h1, {31'h0, modem_change});
    chk("status", 32'h0f, {24'h0, modem_line_status});
    rd(STA, 8'h0f);
    act <= 4'h0;
    rd(STA, 8'h00);
    tx_shift_out <= 1'b1;
    bus(1'b1, CTL, 32'h1f);
    pins(5'h1f);
    rd(STA, 8'hfb);
    bus(1'b1, CTL, 32'h1b);
    rd(STA, 8'hb4);
    // Leaving loopback: one read discards stale change bits
    rxd_lvl <= 1'b0;
    bus(1'b1, CTL, 32'h00);
    rd(STA, 8'h0b);
    rd(STA, 8'h00);
    pins(5'h1e);
    rd(8'h08, 8'h00);
    test_done();
  end
endmodule : uml_modem_loop_test
`default_nettype wire
